/* inc/moes_defs.svh */
// moes_defs.svh: cycle counts, instruction lengths, fixed addresses and reset values
// assumes: included by the execution subset core; holds definitions only
`ifndef MOES_DEFS_SVH
`define MOES_DEFS_SVH

// cycle counts at the 100 MHz system clock
`define MOES_NOP_CYC        1
`define MOES_PTR_CYC        1
`define MOES_LOGIC_ACC_CYC  3
`define MOES_LOGIC_IMM_CYC  6
`define MOES_LCD_CYC        3
`define MOES_ROT_BASE_CYC   1
`define MOES_EE_CYC         65536
`define MOES_ROUTINE_CYC    8

// instruction lengths in bytes
`define MOES_NOP_LEN        1
`define MOES_PTR_LEN        1
`define MOES_LOGIC_ACC_LEN  2
`define MOES_LOGIC_IMM_LEN  5
`define MOES_EE_LEN         4
`define MOES_DIGITS_LEN     3
`define MOES_LCD_LEN        2
`define MOES_AVG_LEN        2
`define MOES_ROT_ONE_LEN    1
`define MOES_ROT_CNT_LEN    2

// fixed addresses and operand ranges
`define MOES_AVG_RAM_ADDR   7'h0d
`define MOES_EE_CELL_LO     7'h0e
`define MOES_EE_CELL_HI     7'h0f
`define MOES_WIN_MIN        5'h03
`define MOES_WIN_MAX        17
`define MOES_DP_MIN         3'h1
`define MOES_DP_MAX         3'h6

// reset values
`define MOES_PTR_RST        7'h00
`define MOES_ACC_RST        24'h000000
`define MOES_SEG_RST        24'h000000

`endif

/* inc/moes_pkg.sv */
// moes_pkg: opcode and sequencer state types of the execution subset
// assumes: compiled before the design modules
package moes_pkg;

    typedef enum logic [3:0] {
        op_nop        = 4'h0,
        op_nor        = 4'h1,
        op_or         = 4'h2,
        op_ee_write   = 4'h3,
        op_set_ptr    = 4'h4,
        op_digits_to_segments  = 4'h5,
        op_refresh    = 4'h6,
        op_moving_average_step = 4'h7,
        op_rotate_left_carry   = 4'h8
    } moes_op_t;

    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_wait = 1'b1
    } moes_state_t;

endpackage

/* design/moes_seg_conv.sv */
// moes_seg_conv: six packed decimal digits to seven-segment patterns with point and blanking
// assumes: combinational; the caller registers the result
`timescale 1ns/100ps
module moes_seg_conv
(
    input  wire logic [23:0] digits,
    input  wire logic [2:0]  point,
    output logic      [23:0] seg_hi,
    output logic      [23:0] seg_lo
);

    // segment order a..g in bits 0..6; non-decimal nibbles show blank
    function automatic logic [6:0] seg7(input logic [3:0] d);
        case (d)
            4'h0:    seg7 = 7'h3f;
            4'h1:    seg7 = 7'h06;
            4'h2:    seg7 = 7'h5b;
            4'h3:    seg7 = 7'h4f;
            4'h4:    seg7 = 7'h66;
            4'h5:    seg7 = 7'h6d;
            4'h6:    seg7 = 7'h7d;
            4'h7:    seg7 = 7'h07;
            4'h8:    seg7 = 7'h7f;
            4'h9:    seg7 = 7'h6f;
            default: seg7 = 7'h00;
        endcase
    endfunction

    // walk from the top digit; zeros stay blank until a nonzero digit or the point digit
    always_comb
    begin
        logic        lead;
        logic [3:0]  d;
        logic [47:0] pat;
        lead = 1'b1;
        d    = 4'h0;
        pat  = 48'h0;
        for (int k = 5; k >= 0; k--)
        begin
            d = digits[k*4 +: 4];
            if (d != 4'h0 || k < int'(point))
                lead = 1'b0;
            pat[k*8 +: 8] = {(k + 1 == int'(point)), (lead ? 7'h00 : seg7(d))};
        end
        seg_hi = pat[47:24];
        seg_lo = pat[23:0];
    end

endmodule

/* design/moes_core.sv */
// moes_core: execution of display, logic, nonvolatile write, pointer, average and rotate opcodes
// assumes: a fetch stage presents one decoded instruction with EXEC_START while BUSY is low
//
// What this block does
// - nop: one byte, one cycle, no change
// - nor writes negated or, flags S Z
// - nor: 2B/3cyc accumulator, 5B/6cyc immediate
// - or writes bitwise or, flags S Z
// - or: 2B/3cyc accumulator, 5B/6cyc immediate
// - nonvolatile write copies accumulator, flags kept
// - only cells 14 and 15 are written
// - nonvolatile write holds one stack entry
// - pointer load: one byte, one cycle
// - six digits of x to segments
// - point position 1-6, leading zeros blanked
// - patterns land in regs 61, 62 only
// - refresh copies regs 61-63 to display
// - average window 3-17, outgoing sample to 13
// - new average x, previous y, flags kept
// - average and digits run as routine calls
// - rotate left through carry, flags last step
// - old carry into bit 0, 1+count cycles
`timescale 1ns/100ps
`include "moes_defs.svh"
module moes_core
    import moes_pkg::*;
#(
    parameter int EE_CYCLES      = `MOES_EE_CYC,
    parameter int ROUTINE_CYCLES = `MOES_ROUTINE_CYC,
    parameter int WIN_MAX        = `MOES_WIN_MAX
)
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    input  wire logic        EXEC_START,
    input  wire logic [3:0]  OPCODE,
    input  wire logic [1:0]  DST_SEL,
    input  wire logic [1:0]  SRC_SEL,
    input  wire logic        SRC_IS_IMM,
    input  wire logic [23:0] IMM_DATA,
    input  wire logic [4:0]  ARG,
    input  wire logic [23:0] SEG_REG63,
    output logic             BUSY,
    output logic             DONE,
    output logic             ILLEGAL,
    output logic      [2:0]  INSTR_LEN,
    output logic      [23:0] ACC_X,
    output logic      [23:0] ACC_Y,
    output logic      [23:0] ACC_Z,
    output logic      [23:0] ACC_R,
    output logic             FLAG_C,
    output logic             FLAG_O,
    output logic             FLAG_S,
    output logic             FLAG_Z,
    output logic      [6:0]  RAM_PTR,
    output logic             EE_WR,
    output logic      [6:0]  EE_ADDR,
    output logic      [23:0] EE_DATA,
    output logic             RAM_WR,
    output logic      [6:0]  RAM_ADDR,
    output logic      [23:0] RAM_DATA,
    output logic      [23:0] SEG_REG61,
    output logic      [23:0] SEG_REG62,
    output logic      [71:0] LCD_SEG,
    output logic             STACK_PUSH,
    output logic             STACK_POP
);

    // the counters and the window array are sized for these limits
    if (EE_CYCLES < 2 || EE_CYCLES > 131071 || ROUTINE_CYCLES < 2 || ROUTINE_CYCLES > 131071)
        $error("moes_core: cycle parameters out of range");
    if (WIN_MAX < 17 || WIN_MAX > 31)
        $error("moes_core: WIN_MAX out of range");

    moes_state_t       state;
    logic [16:0]       rem;
    moes_op_t          op_l;
    logic [1:0]        dst_l;
    logic [1:0]        src_l;
    logic              imm_sel_l;
    logic [23:0]       imm_l;
    logic [4:0]        arg_l;
    logic [23:0]       acc [4];
    logic [23:0]       prev_avg;
    logic [23:0]       win [WIN_MAX];
    logic [4:0]        win_idx;
    logic signed [28:0] win_sum;
    logic [16:0]       wait_cnt;

    moes_op_t          cur_op;
    logic [1:0]        cur_dst;
    logic              cur_imm_sel;
    logic [4:0]        cur_arg;
    logic [23:0]       dst_val;
    logic [23:0]       src_val;
    logic              take;
    logic              fin;
    logic              bad;
    logic [16:0]       n_cyc;
    logic [2:0]        cur_len;
    logic [25:0]       rot_res;
    logic [23:0]       seg_hi;
    logic [23:0]       seg_lo;
    logic signed [28:0] next_sum;
    logic signed [28:0] avg_full;

    // rotate left through carry; returns {carry, overflow, value} of the last step
    function automatic logic [25:0] rot_steps(input logic [23:0] v, input logic c, input logic [3:0] n);
        logic [23:0] r;
        logic        cy;
        logic        ov;
        r  = v;
        cy = c;
        ov = 1'b0;
        for (int i = 0; i < 16; i++)
            if (i < ((n == 4'h0) ? 1 : int'(n)))
            begin
                ov      = r[23] ^ r[22];
                {cy, r} = {r, cy};  // old carry enters bit 0
            end
        return {cy, ov, r};
    endfunction

    // live fields while idle, latched ones while an instruction runs
    assign take        = EXEC_START && state == st_idle;
    assign cur_op      = (state == st_idle) ? moes_op_t'(OPCODE) : op_l;
    assign cur_dst     = (state == st_idle) ? DST_SEL : dst_l;
    assign cur_imm_sel = (state == st_idle) ? SRC_IS_IMM : imm_sel_l;
    assign cur_arg     = (state == st_idle) ? ARG : arg_l;
    assign dst_val     = acc[cur_dst];
    assign src_val     = (state == st_idle) ? (SRC_IS_IMM ? IMM_DATA : acc[SRC_SEL])
                                            : (imm_sel_l ? imm_l : acc[src_l]);
    assign rot_res     = rot_steps(dst_val, FLAG_C, cur_arg[3:0]);

    // operand checks, cycle count and length per opcode
    always_comb
    begin
        bad     = 1'b0;
        n_cyc   = 17'(`MOES_NOP_CYC);
        cur_len = 3'(`MOES_NOP_LEN);
        case (cur_op)
            op_nop:
            begin
                n_cyc   = 17'(`MOES_NOP_CYC);
                cur_len = 3'(`MOES_NOP_LEN);
            end
            op_nor, op_or:
            begin
                n_cyc   = cur_imm_sel ? 17'(`MOES_LOGIC_IMM_CYC) : 17'(`MOES_LOGIC_ACC_CYC);
                cur_len = cur_imm_sel ? 3'(`MOES_LOGIC_IMM_LEN) : 3'(`MOES_LOGIC_ACC_LEN);
            end
            op_ee_write:
            begin
                n_cyc   = 17'(EE_CYCLES);
                cur_len = 3'(`MOES_EE_LEN);
            end
            op_set_ptr:
            begin
                n_cyc   = 17'(`MOES_PTR_CYC);
                cur_len = 3'(`MOES_PTR_LEN);
            end
            op_digits_to_segments:
            begin
                bad     = cur_arg[2:0] < `MOES_DP_MIN || cur_arg[2:0] > `MOES_DP_MAX || cur_arg[4:3] != 2'h0;
                n_cyc   = 17'(ROUTINE_CYCLES);
                cur_len = 3'(`MOES_DIGITS_LEN);
            end
            op_refresh:
            begin
                n_cyc   = 17'(`MOES_LCD_CYC);
                cur_len = 3'(`MOES_LCD_LEN);
            end
            op_moving_average_step:
            begin
                bad     = cur_arg < `MOES_WIN_MIN || cur_arg > 5'(`MOES_WIN_MAX);
                n_cyc   = 17'(ROUTINE_CYCLES);
                cur_len = 3'(`MOES_AVG_LEN);
            end
            op_rotate_left_carry:
            begin
                n_cyc   = 17'(`MOES_ROT_BASE_CYC) + 17'(cur_arg[3:0]);
                cur_len = (cur_arg[3:0] == 4'h0) ? 3'(`MOES_ROT_ONE_LEN) : 3'(`MOES_ROT_CNT_LEN);
            end
            default:
                bad = 1'b1;
        endcase
        if (bad)
            n_cyc = 17'(`MOES_NOP_CYC);
    end

    assign fin = (take && n_cyc == 17'h1) || (state == st_wait && rem == 17'h1);

    // sequencer: latch the instruction, count its cycles, report completion
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state     <= st_idle;
            rem       <= 17'h0;
            op_l      <= op_nop;
            dst_l     <= 2'h0;
            src_l     <= 2'h0;
            imm_sel_l <= 1'b0;
            imm_l     <= 24'h0;
            arg_l     <= 5'h0;
            BUSY      <= 1'b0;
            DONE      <= 1'b0;
            ILLEGAL   <= 1'b0;
            INSTR_LEN <= 3'h0;
        end
        else
        begin
            DONE    <= fin;
            ILLEGAL <= fin && bad;
            if (fin)
                INSTR_LEN <= cur_len;
            if (take)
            begin
                op_l      <= moes_op_t'(OPCODE);
                dst_l     <= DST_SEL;
                src_l     <= SRC_SEL;
                imm_sel_l <= SRC_IS_IMM;
                imm_l     <= IMM_DATA;
                arg_l     <= ARG;
            end
            if (take && n_cyc != 17'h1)
            begin
                state <= st_wait;
                rem   <= n_cyc - 17'h1;
                BUSY  <= 1'b1;
            end
            else if (state == st_wait)
            begin
                rem <= rem - 17'h1;
                if (rem == 17'h1)
                begin
                    state <= st_idle;
                    BUSY  <= 1'b0;
                end
            end
        end
    end

    // moving average arithmetic: drop the oldest sample, add x, divide by the window size
    assign next_sum = win_sum - 29'(signed'(win[win_idx])) + 29'(signed'(acc[0]));
    assign avg_full = next_sum / signed'({24'h0, cur_arg});

    // accumulators and flags, committed on the last cycle of an instruction
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            for (int i = 0; i < 4; i++)
                acc[i] <= `MOES_ACC_RST;
            prev_avg <= `MOES_ACC_RST;
            FLAG_C   <= 1'b0;
            FLAG_O   <= 1'b0;
            FLAG_S   <= 1'b0;
            FLAG_Z   <= 1'b0;
        end
        else if (fin && !bad)
        begin
            case (cur_op)
                op_nor:
                begin
                    acc[cur_dst] <= ~(dst_val | src_val);
                    FLAG_S       <= ~(dst_val[23] | src_val[23]);
                    FLAG_Z       <= (dst_val | src_val) == 24'hffffff;
                end
                op_or:
                begin
                    acc[cur_dst] <= dst_val | src_val;
                    FLAG_S       <= dst_val[23] | src_val[23];
                    FLAG_Z       <= (dst_val | src_val) == 24'h0;
                end
                op_moving_average_step:
                begin
                    acc[0]   <= avg_full[23:0];  // flags untouched
                    acc[1]   <= prev_avg;
                    prev_avg <= avg_full[23:0];
                end
                op_rotate_left_carry:
                begin
                    acc[cur_dst] <= rot_res[23:0];
                    FLAG_C       <= rot_res[25];
                    FLAG_O       <= rot_res[24];
                    FLAG_S       <= rot_res[23];
                    FLAG_Z       <= rot_res[23:0] == 24'h0;
                end
                default:
                begin
                end
            endcase
        end
    end

    // pointer changes only on its own load instruction
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            RAM_PTR <= `MOES_PTR_RST;
        else if (fin && cur_op == op_set_ptr)
            RAM_PTR <= {2'h0, cur_arg};
    end

    // nonvolatile write strobe at the start of the stall, refused outside cells 14 and 15
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            EE_WR   <= 1'b0;
            EE_ADDR <= 7'h0;
            EE_DATA <= 24'h0;
        end
        else
        begin
            EE_WR <= take && cur_op == op_ee_write
                     && (RAM_PTR == `MOES_EE_CELL_LO || RAM_PTR == `MOES_EE_CELL_HI);
            if (take && cur_op == op_ee_write)
            begin
                EE_ADDR <= RAM_PTR;
                EE_DATA <= acc[DST_SEL];
            end
        end
    end

    // average window store; the sample leaving the window goes to RAM
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            for (int i = 0; i < WIN_MAX; i++)
                win[i] <= 24'h0;
            win_idx  <= 5'h0;
            win_sum  <= 29'sh0;
            RAM_WR   <= 1'b0;
            RAM_ADDR <= 7'h0;
            RAM_DATA <= 24'h0;
        end
        else
        begin
            RAM_WR <= fin && !bad && cur_op == op_moving_average_step;
            if (fin && !bad && cur_op == op_moving_average_step)
            begin
                RAM_ADDR      <= `MOES_AVG_RAM_ADDR;
                RAM_DATA      <= win[win_idx];
                win[win_idx]  <= acc[0];
                win_sum       <= next_sum;
                win_idx       <= (win_idx + 5'h1 >= cur_arg) ? 5'h0 : win_idx + 5'h1;
            end
        end
    end

    moes_seg_conv u_seg_conv
    (
        .digits (acc[0]),
        .point  (cur_arg[2:0]),
        .seg_hi (seg_hi),
        .seg_lo (seg_lo)
    );

    // segment registers and the display image
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            SEG_REG61 <= `MOES_SEG_RST;
            SEG_REG62 <= `MOES_SEG_RST;
            LCD_SEG   <= 72'h0;
        end
        else if (fin && !bad && cur_op == op_digits_to_segments)
        begin
            SEG_REG61 <= seg_hi;  // display unchanged until refresh
            SEG_REG62 <= seg_lo;
        end
        else if (fin && cur_op == op_refresh)
            LCD_SEG <= {SEG_REG63, SEG_REG62, SEG_REG61};
    end

    // one stack entry held by the write and the routine calls while they run
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            STACK_PUSH <= 1'b0;
            STACK_POP  <= 1'b0;
        end
        else
        begin
            STACK_PUSH <= take && !bad && (cur_op == op_ee_write || cur_op == op_digits_to_segments
                          || cur_op == op_moving_average_step);
            STACK_POP  <= fin && !take && (op_l == op_ee_write || op_l == op_digits_to_segments
                          || op_l == op_moving_average_step);
        end
    end

    // cycles spent waiting, for the stall check
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            wait_cnt <= 17'h0;
        else
            wait_cnt <= (state == st_wait && !fin) ? wait_cnt + 17'h1 : 17'h0;
    end

    assign ACC_X = acc[0];
    assign ACC_Y = acc[1];
    assign ACC_Z = acc[2];
    assign ACC_R = acc[3];

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    nop_no_change_a: assert property ((take && cur_op == op_nop) |=> DONE && !BUSY
        && $stable(ACC_X) && $stable(ACC_Y) && $stable(FLAG_C) && $stable(FLAG_Z) && $stable(RAM_PTR))
        else $error("nop changed state or took extra cycles");
    nor_value_a: assert property ((fin && cur_op == op_nor) |=>
        acc[$past(cur_dst)] == ~($past(dst_val) | $past(src_val)) && FLAG_C == $past(FLAG_C))
        else $error("nor result or carry wrong");
    nor_imm_time_a: assert property ((take && cur_op == op_nor && SRC_IS_IMM) |=>
        BUSY[*5] ##1 (DONE && !BUSY && INSTR_LEN == 3'h5))
        else $error("immediate nor timing wrong");
    or_flags_a: assert property ((fin && cur_op == op_or) |=>
        FLAG_S == acc[$past(cur_dst)][23] && FLAG_Z == (acc[$past(cur_dst)] == 24'h0))
        else $error("or flags wrong");
    or_acc_time_a: assert property ((take && cur_op == op_or && !SRC_IS_IMM) |=>
        BUSY[*2] ##1 (DONE && INSTR_LEN == 3'h2))
        else $error("accumulator or timing wrong");
    ee_cell_guard_a: assert property (EE_WR |->
        (EE_ADDR == `MOES_EE_CELL_LO || EE_ADDR == `MOES_EE_CELL_HI) && $stable(FLAG_Z))
        else $error("write to a protected cell");
    ee_stall_len_a: assert property ((state == st_wait && rem == 17'h1 && op_l == op_ee_write) |->
        wait_cnt == 17'(EE_CYCLES - 2))
        else $error("nonvolatile stall length wrong");
    stack_hold_a: assert property (STACK_PUSH |-> BUSY ##1 (BUSY throughout (!STACK_PUSH)[*1]))
        else $error("stack entry taken without a running call");
    ptr_keep_a: assert property (!(fin && cur_op == op_set_ptr) |=> $stable(RAM_PTR))
        else $error("pointer changed by another instruction");
    refresh_copy_a: assert property ((fin && cur_op == op_refresh) |=>
        LCD_SEG == {$past(SEG_REG63), SEG_REG62, SEG_REG61})
        else $error("display image not refreshed");
    rot_carry_a: assert property ((fin && cur_op == op_rotate_left_carry && cur_arg[3:0] == 4'h0) |=>
        FLAG_C == $past(dst_val[23]) && acc[$past(cur_dst)] == {$past(dst_val[22:0]), $past(FLAG_C)})
        else $error("single rotate wrong");

endmodule

/* tb/moes_tb.sv */
// moes_tb: self-checking bench for the execution subset core
// assumes: moes_pkg compiled first; the core checks its own assertions
`timescale 1ns/100ps
module testbench
    import moes_pkg::*;
;
    localparam int EE_N = 8;
    localparam int RT_N = 8;
    logic        ref_clk, rst_b, exec_start, src_is_imm, busy, done, illegal;
    logic [3:0]  opcode;
    logic [1:0]  dst_sel, src_sel;
    logic [23:0] imm_data, seg_reg63, acc_x, acc_y, acc_z, acc_r, ee_data, ram_data, seg_reg61, seg_reg62;
    logic [4:0]  arg;
    logic [2:0]  instr_len;
    logic        flag_c, flag_o, flag_s, flag_z, ee_wr, ram_wr, stack_push, stack_pop;
    logic [6:0]  ram_ptr, ee_addr, ram_addr;
    logic [71:0] lcd_seg, lcd_old;
    int          bad_count, samples_checked, cyc, pushes, pops, ees, rams, ills, busys, hist[$], sum, prev;
    logic [23:0] a, b, v, r;
    logic [1:0]  d;
    logic        im, c, o;
    logic [3:0]  flg;
    logic [106:0] snap;

    moes_core #(.EE_CYCLES(EE_N), .ROUTINE_CYCLES(RT_N), .WIN_MAX(17)) dut (
        .REF_CLK(ref_clk), .RST_B(rst_b), .EXEC_START(exec_start), .OPCODE(opcode), .DST_SEL(dst_sel),
        .SRC_SEL(src_sel), .SRC_IS_IMM(src_is_imm), .IMM_DATA(imm_data), .ARG(arg), .SEG_REG63(seg_reg63),
        .BUSY(busy), .DONE(done), .ILLEGAL(illegal), .INSTR_LEN(instr_len), .ACC_X(acc_x), .ACC_Y(acc_y),
        .ACC_Z(acc_z), .ACC_R(acc_r), .FLAG_C(flag_c), .FLAG_O(flag_o), .FLAG_S(flag_s), .FLAG_Z(flag_z),
        .RAM_PTR(ram_ptr), .EE_WR(ee_wr), .EE_ADDR(ee_addr), .EE_DATA(ee_data), .RAM_WR(ram_wr),
        .RAM_ADDR(ram_addr), .RAM_DATA(ram_data), .SEG_REG61(seg_reg61), .SEG_REG62(seg_reg62),
        .LCD_SEG(lcd_seg), .STACK_PUSH(stack_push), .STACK_POP(stack_pop));

    // 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [23:0] acc(input logic [1:0] i);
        return (i == 2'h0) ? acc_x : (i == 2'h1) ? acc_y : (i == 2'h2) ? acc_z : acc_r;
    endfunction

    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one-cycle pulses are counted while an instruction runs
    task automatic grab();
        pushes += (stack_push === 1'b1);
        pops   += (stack_pop === 1'b1);
        ees    += (ee_wr === 1'b1);
        rams   += (ram_wr === 1'b1);
        ills   += (illegal === 1'b1);
        busys  += (busy === 1'b1);
    endtask

    // present one instruction, then count edges until it completes
    task automatic exec(input logic [3:0] op, input logic [1:0] dd, input logic [1:0] s, input logic i,
                        input logic [23:0] val, input logic [4:0] ar);
        @(posedge ref_clk);
        #1;
        {opcode, dst_sel, src_sel, src_is_imm, imm_data, arg, exec_start} = {op, dd, s, i, val, ar, 1'b1};
        @(posedge ref_clk);
        #1;
        exec_start = 1'b0;
        {cyc, pushes, pops, ees, rams, ills, busys} = {32'd1, 32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd0};
        grab();
        while (done !== 1'b1 && cyc < 70000)
        begin
            @(posedge ref_clk);
            #1;
            cyc++;
            grab();
        end
    endtask

    task automatic load(input logic [1:0] dd, input logic [23:0] val);
        exec(4'h1, dd, 2'h0, 1'b1, 24'hffffff, 5'h0);
        exec(4'h2, dd, 2'h0, 1'b1, val, 5'h0);
    endtask

    // watchdog
    initial
    begin
        #400000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        {rst_b, exec_start, opcode, dst_sel, src_sel, src_is_imm, imm_data, arg, seg_reg63} = '0;
        void'($urandom(32'h33f0c1fd));
        repeat (12) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        chk("lcd_seg", lcd_seg, 0);
        // logic operations, both source kinds
        for (int i = 0; i < 12; i++)
        begin
            d = $urandom;
            src_sel = $urandom;
            im = (i < 2) ? i[0] : $urandom;
            v = (i == 3) ? 24'hffffff : $urandom;
            a = acc(d);
            b = im ? v : acc(src_sel);
            c = flag_c;
            r = i[0] ? ~(a | b) : (a | b);
            exec(i[0] ? 4'h1 : 4'h2, d, src_sel, im, v, 5'h0);
            chk("logic", acc(d), r);
            chk("flags", {flag_c, flag_s, flag_z}, {c, r[23], r == 0});
            chk("logic_cyc", cyc, im ? 6 : 3);
            chk("logic_len", instr_len, im ? 5 : 2);
        end
        snap = {acc_x, acc_y, acc_z, acc_r, flag_c, flag_o, flag_s, flag_z, ram_ptr};
        exec(4'h0, 2'h1, 2'h2, 1'b1, 24'h5a5a5a, 5'h1f);
        chk("nop", {acc_x, acc_y, acc_z, acc_r, flag_c, flag_o, flag_s, flag_z, ram_ptr}, snap);
        chk("nop_cyc", {cyc, instr_len}, {32'd1, 3'h1});
        // rotate left through carry, plain and counted forms
        for (int k = 0; k < 16; k += 5)
        begin
            d = k;
            v = acc(d);
            c = flag_c;
            for (int j = 0; j < ((k == 0) ? 1 : k); j++)
            begin
                o = v[23] ^ v[22];
                {c, v} = {v, c};
            end
            exec(4'h8, d, 2'h0, 1'b0, 24'h0, k);
            chk("rot", acc(d), v);
            chk("rot_flags", {flag_c, flag_o, flag_s, flag_z}, {c, o, v[23], v == 0});
            chk("rot_cyc", {cyc, instr_len}, {1 + k, (k == 0) ? 3'h1 : 3'h2});
        end
        // pointer load then nonvolatile write to allowed and refused cells
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 14 : (i == 1) ? 15 : (i == 2) ? 5 : 13;
            exec(4'h4, 2'h0, 2'h0, 1'b0, 24'h0, a[4:0]);
            chk("ptr", {ram_ptr, cyc, instr_len}, {a[6:0], 32'd1, 3'h1});
            d = $urandom;
            v = acc(d);
            flg = {flag_c, flag_o, flag_s, flag_z};
            exec(4'h3, d, 2'h0, 1'b0, 24'h0, 5'h0); // issued plain, never under a skip opcode
            chk("ee_hits", ees, (a >= 14) ? 1 : 0);
            if (a >= 14)
                chk("ee_cell", {ee_addr, ee_data}, {a[6:0], v});
            chk("ee_stack", {pushes, pops}, {32'd1, 32'd1});
            chk("ee_cyc", {cyc, instr_len, busys}, {EE_N, 3'h4, EE_N - 1});
            chk("ee_keep", {flag_c, flag_o, flag_s, flag_z, ram_ptr}, {flg, a[6:0]});
        end
        // digits to segments with point at both ends, then refresh
        for (int p = 1; p <= 6; p += 5)
        begin
            load(2'h0, 24'h000000);
            lcd_old = lcd_seg;
            exec(4'h5, 2'h0, 2'h0, 1'b0, 24'h0, p);
            if (p == 1)
                chk("blank", {seg_reg61, seg_reg62[23:7]}, {40'h0, 1'b1});
            else
                chk("point6", {seg_reg61[23], seg_reg62[7:0] == 0}, 2'b10);
            chk("lcd_hold", lcd_seg, lcd_old);
            chk("dig_call", {pushes, pops, cyc, instr_len}, {32'd1, 32'd1, RT_N, 3'h3});
            seg_reg63 = $urandom;
            exec(4'h6, 2'h0, 2'h0, 1'b0, 24'h0, 5'h0);
            chk("refresh", lcd_seg, {seg_reg63, seg_reg62, seg_reg61});
            chk("ref_cyc", {cyc, instr_len}, {32'd3, 3'h2});
        end
        // moving average over the shortest window
        repeat (17) hist.push_back(0);
        prev = 0;
        repeat (5)
        begin
            v = $urandom;
            load(2'h0, v);
            flg = {flag_c, flag_o, flag_s, flag_z};
            hist.push_back(int'($signed(v)));
            sum = hist[$] + hist[$ - 1] + hist[$ - 2];
            exec(4'h7, 2'h0, 2'h0, 1'b0, 24'h0, 5'h3);
            chk("avg_x", acc_x, 24'(sum / 3));
            chk("avg_y", acc_y, 24'(prev));
            chk("avg_out", {rams, ram_addr, ram_data}, {32'd1, 7'h0d, 24'(hist[$ - 3])});
            chk("avg_flags", {flag_c, flag_o, flag_s, flag_z}, flg);
            chk("avg_call", {pushes, pops, cyc, instr_len}, {32'd1, 32'd1, RT_N, 3'h2});
            prev = sum / 3;
        end
        exec(4'hf, 2'h0, 2'h0, 1'b0, 24'h0, 5'h0);
        chk("illegal", {ills, cyc, ram_ptr}, {32'd1, 32'd1, 7'h0d});
        exec(4'h7, 2'h0, 2'h0, 1'b0, 24'h0, 5'h2);
        chk("win_range", {ills, rams, pushes}, {32'd1, 32'd0, 32'd0});
        wrap_up();
    end
endmodule
